// ---- core/gpjk_defines.vh ----
// constants for the port j / port k pin block
`ifndef GPJK_DEFINES_VH
`define GPJK_DEFINES_VH

// ==============================
// register byte offsets, port k window then port j window
`define GPJK_OFF_K_DATA   8'h00
`define GPJK_OFF_K_OUTEN  8'h04
`define GPJK_OFF_K_FUNA   8'h08
`define GPJK_OFF_K_FUNB   8'h0C
`define GPJK_OFF_K_PULL   8'h2C
`define GPJK_OFF_K_INEN   8'h38
`define GPJK_OFF_J_DATA   8'h40
`define GPJK_OFF_J_OUTEN  8'h44
`define GPJK_OFF_J_FUNA   8'h48
`define GPJK_OFF_J_PULL   8'h6C
`define GPJK_OFF_J_INEN   8'h78
`define GPJK_OFF_J_INPUT  8'h7C
`define GPJK_OFF_K_INPUT  8'h3C

// ==============================
// widths, reset values, field positions
`define GPJK_K_W          3
`define GPJK_J_W          8
`define GPJK_K_RST        3'h0
`define GPJK_J_RST        8'h00
`define GPJK_K_FUNB_MASK  3'h2
`define GPJK_K_PULL_MASK  3'h6
`define GPJK_K_OD_MASK    3'h1
`define GPJK_K_PER_OE     3'h7
`define GPJK_J_IRQ_MASK   8'hCF
`define GPJK_J_TMR6_BIT   4
`define GPJK_J_TMR7_BIT   5
`define GPJK_K_CEC_BIT    0
`define GPJK_K_CLK_BIT    1
`define GPJK_K_TMR9_BIT   2
`define GPJK_ZERO32       32'h00000000

`endif

// ---- core/gpjk_pin_cell.v ----
// one group of pins: output select, enable and input gating
`timescale 1ns/10ps
module gpjk_pin_cell #(
  parameter W = 8
) (
  // register side
  input  wire [W-1:0] data_i,
  input  wire [W-1:0] outen_i,
  input  wire [W-1:0] func_i,
  input  wire [W-1:0] inen_i,
  input  wire [W-1:0] opendrain_i,
  // peripheral side
  input  wire [W-1:0] per_out_i,
  input  wire [W-1:0] per_oe_i,
  // pad side
  input  wire [W-1:0] pad_i,
  output wire [W-1:0] pad_o,
  output wire [W-1:0] pad_oe_o,
  output wire [W-1:0] in_o
);
  // ==============================
  // selection
  wire [W-1:0] drive_val;
  wire [W-1:0] drive_en;
  assign drive_val = (func_i & per_out_i) | (~func_i & data_i);
  assign drive_en  = outen_i & (~func_i | per_oe_i);
  // open drain never drives high
  assign pad_o    = drive_val & ~opendrain_i;
  assign pad_oe_o = drive_en & ~(drive_val & opendrain_i);
  // disabled buffer reads zero, not the floating pad
  assign in_o     = pad_i & inen_i;
endmodule // gpjk_pin_cell

// ---- core/gpjk_top.v ----
// port j (8 pins) and port k (3 pins) registers, function mux, wishbone slave
// Notes on behaviour
// - port k has exactly three pins
// - direction set independently per pin
// - port k resets to port, all off
// - port k pin zero is open drain
// - k data at 0x00, output control 0x04
// - k function registers at 0x08, 0x0C
// - k pull-up 0x2C, input enable 0x38
// - k data bits 2-0, upper read zero
// - k output control bit enables driver
// - k function a: timer9, clock, cec
// - k function b bit1 routes alarm only
// - j function: irq lines, timer 7/6
// - j pull-up per bit, upper zero
// - j input enable per bit, reset zero
// - j irq follows input enable outside stop
// - port j resets to port, all off
// - j function 0x08, pull-up 0x2C, input 0x38
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "gpjk_defines.vh"
module gpjk_top (
  // clock and reset
  input  wire        mclk_i,
  input  wire        reset_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // system state
  input  wire        deep_stop_i,
  // peripheral signals
  input  wire        timer_six_output_i,
  input  wire        timer_seven_output_i,
  input  wire        timer_nine_output_i,
  input  wire        system_clock_output_i,
  input  wire        alarm_output_i,
  input  wire        cec_drive_low_i,
  output wire        cec_line_o,
  output wire [7:0]  external_irq_line_o,
  // port j pads
  input  wire [7:0]  port_j_pad_i,
  output wire [7:0]  port_j_pad_o,
  output wire [7:0]  port_j_pad_oe_o,
  output wire [7:0]  port_j_pullup_o,
  // port k pads
  input  wire [2:0]  port_k_pad_i,
  output wire [2:0]  port_k_pad_o,
  output wire [2:0]  port_k_pad_oe_o,
  output wire [2:0]  port_k_pullup_o
);
  // ==============================
  // registers
  reg [`GPJK_K_W-1:0] port_k_pin_data_ff;
  reg [`GPJK_K_W-1:0] port_k_output_drive_enable_ff;
  reg [`GPJK_K_W-1:0] port_k_function_select_a_ff;
  reg [`GPJK_K_W-1:0] port_k_function_select_b_ff;
  reg [`GPJK_K_W-1:0] port_k_pullup_enable_ff;
  reg [`GPJK_K_W-1:0] port_k_input_buffer_enable_ff;
  reg [`GPJK_J_W-1:0] port_j_pin_data_ff;
  reg [`GPJK_J_W-1:0] port_j_output_drive_enable_ff;
  reg [`GPJK_J_W-1:0] port_j_function_select_a_ff;
  reg [`GPJK_J_W-1:0] port_j_pullup_enable_ff;
  reg [`GPJK_J_W-1:0] port_j_input_buffer_enable_ff;
  reg                 ack_ff;
  reg [31:0]          nxt_rdata;

  wire [`GPJK_K_W-1:0] k_in;
  wire [`GPJK_J_W-1:0] j_in;

  // ==============================
  // bus handshake: one wait state, ack drops the cycle after
  wire req;
  wire wr;
  assign req      = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = ack_ff;

  // only the low byte holds data, so lane 0 gates every write
  function hit;
    input [7:0] adr;
    input [7:0] off;
    begin
      hit = (adr == off);
    end
  endfunction

  // ==============================
  // register writes
  always @(posedge mclk_i) begin
    if (reset_i) begin
      ack_ff                        <= 1'b0;
      port_k_pin_data_ff            <= `GPJK_K_RST;
      port_k_output_drive_enable_ff <= `GPJK_K_RST;
      port_k_function_select_a_ff   <= `GPJK_K_RST;
      port_k_function_select_b_ff   <= `GPJK_K_RST;
      port_k_pullup_enable_ff       <= `GPJK_K_RST;
      port_k_input_buffer_enable_ff <= `GPJK_K_RST;
      port_j_pin_data_ff            <= `GPJK_J_RST;
      port_j_output_drive_enable_ff <= `GPJK_J_RST;
      port_j_function_select_a_ff   <= `GPJK_J_RST;
      port_j_pullup_enable_ff       <= `GPJK_J_RST;
      port_j_input_buffer_enable_ff <= `GPJK_J_RST;
    end else begin
      ack_ff <= req;
      if (wr) begin
        if (hit(wb_adr_i, `GPJK_OFF_K_DATA)) begin
          port_k_pin_data_ff <= wb_dat_i[`GPJK_K_W-1:0];
        end
        if (hit(wb_adr_i, `GPJK_OFF_K_OUTEN)) begin
          port_k_output_drive_enable_ff <= wb_dat_i[`GPJK_K_W-1:0];
        end
        if (hit(wb_adr_i, `GPJK_OFF_K_FUNA)) begin
          port_k_function_select_a_ff <= wb_dat_i[`GPJK_K_W-1:0];
        end
        if (hit(wb_adr_i, `GPJK_OFF_K_FUNB)) begin
          port_k_function_select_b_ff <= wb_dat_i[`GPJK_K_W-1:0]
                                         & `GPJK_K_FUNB_MASK;
        end
        if (hit(wb_adr_i, `GPJK_OFF_K_PULL)) begin
          port_k_pullup_enable_ff <= wb_dat_i[`GPJK_K_W-1:0] & `GPJK_K_PULL_MASK;
        end
        if (hit(wb_adr_i, `GPJK_OFF_K_INEN)) begin
          port_k_input_buffer_enable_ff <= wb_dat_i[`GPJK_K_W-1:0];
        end
        if (hit(wb_adr_i, `GPJK_OFF_J_DATA)) begin
          port_j_pin_data_ff <= wb_dat_i[`GPJK_J_W-1:0];
        end
        if (hit(wb_adr_i, `GPJK_OFF_J_OUTEN)) begin
          port_j_output_drive_enable_ff <= wb_dat_i[`GPJK_J_W-1:0];
        end
        if (hit(wb_adr_i, `GPJK_OFF_J_FUNA)) begin
          port_j_function_select_a_ff <= wb_dat_i[`GPJK_J_W-1:0];
        end
        if (hit(wb_adr_i, `GPJK_OFF_J_PULL)) begin
          port_j_pullup_enable_ff <= wb_dat_i[`GPJK_J_W-1:0];
        end
        if (hit(wb_adr_i, `GPJK_OFF_J_INEN)) begin
          port_j_input_buffer_enable_ff <= wb_dat_i[`GPJK_J_W-1:0];
        end
      end
    end
  end

  // ==============================
  // read mux, unmapped reads zero and still ack
  always @* begin
    nxt_rdata = `GPJK_ZERO32;
    case (wb_adr_i)
      `GPJK_OFF_K_DATA:  nxt_rdata[`GPJK_K_W-1:0] = port_k_pin_data_ff;
      `GPJK_OFF_K_OUTEN: nxt_rdata[`GPJK_K_W-1:0] = port_k_output_drive_enable_ff;
      `GPJK_OFF_K_FUNA:  nxt_rdata[`GPJK_K_W-1:0] = port_k_function_select_a_ff;
      `GPJK_OFF_K_FUNB:  nxt_rdata[`GPJK_K_W-1:0] = port_k_function_select_b_ff;
      `GPJK_OFF_K_PULL:  nxt_rdata[`GPJK_K_W-1:0] = port_k_pullup_enable_ff;
      `GPJK_OFF_K_INEN:  nxt_rdata[`GPJK_K_W-1:0] = port_k_input_buffer_enable_ff;
      `GPJK_OFF_K_INPUT: nxt_rdata[`GPJK_K_W-1:0] = k_in;
      `GPJK_OFF_J_DATA:  nxt_rdata[`GPJK_J_W-1:0] = port_j_pin_data_ff;
      `GPJK_OFF_J_OUTEN: nxt_rdata[`GPJK_J_W-1:0] = port_j_output_drive_enable_ff;
      `GPJK_OFF_J_FUNA:  nxt_rdata[`GPJK_J_W-1:0] = port_j_function_select_a_ff;
      `GPJK_OFF_J_PULL:  nxt_rdata[`GPJK_J_W-1:0] = port_j_pullup_enable_ff;
      `GPJK_OFF_J_INEN:  nxt_rdata[`GPJK_J_W-1:0] = port_j_input_buffer_enable_ff;
      `GPJK_OFF_J_INPUT: nxt_rdata[`GPJK_J_W-1:0] = j_in;
      default:           nxt_rdata = `GPJK_ZERO32;
    endcase
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      wb_dat_o <= `GPJK_ZERO32;
    end else if (req) begin
      wb_dat_o <= nxt_rdata;
    end
  end

  // ==============================
  // port j: timers drive 4/5, all others are irq inputs
  wire [7:0] j_per_out;
  wire [7:0] j_per_oe;
  assign j_per_out = {2'h0, timer_seven_output_i, timer_six_output_i, 4'h0};
  assign j_per_oe  = ~`GPJK_J_IRQ_MASK;

  gpjk_pin_cell #(.W(`GPJK_J_W)) u_port_j (
    .data_i      (port_j_pin_data_ff),
    .outen_i     (port_j_output_drive_enable_ff),
    .func_i      (port_j_function_select_a_ff),
    .inen_i      (port_j_input_buffer_enable_ff),
    .opendrain_i (`GPJK_J_RST),
    .per_out_i   (j_per_out),
    .per_oe_i    (j_per_oe),
    .pad_i       (port_j_pad_i),
    .pad_o       (port_j_pad_o),
    .pad_oe_o    (port_j_pad_oe_o),
    .in_o        (j_in)
  );
  assign port_j_pullup_o = port_j_pullup_enable_ff;

  // irq seen whenever input enabled; in deep stop only if function selected too
  assign external_irq_line_o = j_in & `GPJK_J_IRQ_MASK
                               & (deep_stop_i ? port_j_function_select_a_ff
                                              : ~`GPJK_J_RST);

  // ==============================
  // port k: pin2 timer9, pin1 clock or alarm, pin0 open-drain cec
  wire [2:0] k_per_out;
  wire       k1_sig;
  // alarm overrides clock output when function b is set
  assign k1_sig    = port_k_function_select_b_ff[`GPJK_K_CLK_BIT] ? alarm_output_i
                                                                  : system_clock_output_i;
  assign k_per_out = {timer_nine_output_i, k1_sig, ~cec_drive_low_i};

  gpjk_pin_cell #(.W(`GPJK_K_W)) u_port_k (
    .data_i      (port_k_pin_data_ff),
    .outen_i     (port_k_output_drive_enable_ff),
    .func_i      (port_k_function_select_a_ff | port_k_function_select_b_ff),
    .inen_i      (port_k_input_buffer_enable_ff),
    .opendrain_i (`GPJK_K_OD_MASK),
    .per_out_i   (k_per_out),
    .per_oe_i    (`GPJK_K_PER_OE),
    .pad_i       (port_k_pad_i),
    .pad_o       (port_k_pad_o),
    .pad_oe_o    (port_k_pad_oe_o),
    .in_o        (k_in)
  );
  assign port_k_pullup_o = port_k_pullup_enable_ff;
  assign cec_line_o      = k_in[`GPJK_K_CEC_BIT];
endmodule // gpjk_top

// ---- bench/gpjk_chk.sv ----
// assertions on the port j / port k block ports
`timescale 1ns/10ps
module gpjk_chk (
  // clock, reset, bus
  input wire        mclk_i,
  input wire        reset_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // pins
  input wire [7:0]  external_irq_line_o,
  input wire [2:0]  port_k_pad_o,
  input wire [2:0]  port_k_pad_oe_o,
  input wire [2:0]  port_k_pullup_o,
  input wire [7:0]  port_j_pad_oe_o,
  input wire [7:0]  port_j_pullup_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // ==============================
  // handshake and read data
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_timing_a: assert property (req_s |=> pulse_s)
    else $error("ack not one pulse after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  // ==============================
  // pins
  open_drain_a: assert property (port_k_pad_oe_o[0] |-> !port_k_pad_o[0])
    else $error("pin zero driven high");
  reset_off_a: assert property ($past(reset_i) |->
    port_k_pad_oe_o == 3'h0 && port_j_pad_oe_o == 8'h00) else $error("driver on after reset");
  timer_irq_a: assert property (external_irq_line_o[5:4] == 2'h0)
    else $error("irq on timer pin");
  k_pull0_a: assert property (port_k_pullup_o[0] == 1'b0)
    else $error("pin zero pull-up set");
  // pull-ups move only when a write is answered
  pull_hold_a: assert property (!(wb_ack_o && wb_we_i) |->
    $stable(port_j_pullup_o) && $stable(port_k_pullup_o)) else $error("pull-up moved");
endmodule // gpjk_chk

bind gpjk_top gpjk_chk i_chk (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .external_irq_line_o(external_irq_line_o), .port_k_pad_o(port_k_pad_o),
  .port_k_pad_oe_o(port_k_pad_oe_o), .port_k_pullup_o(port_k_pullup_o),
  .port_j_pad_oe_o(port_j_pad_oe_o), .port_j_pullup_o(port_j_pullup_o));

// ---- bench/gpjk_board.sv ----
// board model: pull-ups, released lines and external drivers on the pads
`timescale 1ns/10ps
module gpjk_board (
  // clock and external drive
  input  wire       mclk_i,
  input  wire       ext_en_i,
  input  wire [7:0] ext_j_i,
  input  wire [2:0] ext_k_i,
  // pad drive from the block
  input  wire [7:0] j_o_i,
  input  wire [7:0] j_oe_i,
  input  wire [7:0] j_pu_i,
  input  wire [2:0] k_o_i,
  input  wire [2:0] k_oe_i,
  input  wire [2:0] k_pu_i,
  // resolved lines
  output wire [7:0] j_pad_o,
  output wire [2:0] k_pad_o
);
  reg        float_ff = 1'b0;
  wire [7:0] j_idle;
  wire [2:0] k_idle;
  // a floating line wanders each cycle so stale data never passes
  always @(posedge mclk_i) begin
    float_ff <= ~float_ff;
  end
  assign j_idle  = ext_en_i ? ext_j_i : (j_pu_i | {8{float_ff}});
  assign k_idle  = ext_en_i ? ext_k_i : (k_pu_i | {3{float_ff}});
  assign j_pad_o = (j_oe_i & j_o_i) | (~j_oe_i & j_idle);
  assign k_pad_o = (k_oe_i & k_o_i) | (~k_oe_i & k_idle);
endmodule // gpjk_board

// ---- bench/gpio_ports_j_k_function_mux_bench.sv ----
// bench: register map, pin mux and irq checks over wishbone
`timescale 1ns/10ps
module gpio_ports_j_k_function_mux_bench;
  reg         mclk_i = 1'b0, reset_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, deep = 1'b0;
  reg  [7:0]  adr = 8'h00, ext_j = 8'hA5;
  reg  [31:0] wdat = 32'h0, got;
  reg         t6 = 1'b1, t7 = 1'b0, t9 = 1'b1, sck = 1'b1, alm = 1'b1, cec = 1'b0, ext_en = 1'b0;
  reg  [2:0]  ext_k = 3'h2;
  wire [31:0] rdat;
  wire        ack, cec_line;
  wire [7:0]  irq, jo, joe, jpu, jin;
  wire [2:0]  ko, koe, kpu, kin;
  integer     fail_count = 0, compares = 0, i;
  localparam [79:0] OFFS = {8'h10, 8'h78, 8'h6C, 8'h48, 8'h38, 8'h2C, 8'h0C, 8'h08, 8'h04, 8'h00};
  localparam [79:0] MSKS = {8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h06, 8'h02, 8'h07, 8'h07, 8'h07};
  gpjk_top i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .deep_stop_i(deep), .timer_six_output_i(t6), .timer_seven_output_i(t7),
    .timer_nine_output_i(t9), .system_clock_output_i(sck), .alarm_output_i(alm),
    .cec_drive_low_i(cec), .cec_line_o(cec_line), .external_irq_line_o(irq),
    .port_j_pad_i(jin), .port_j_pad_o(jo), .port_j_pad_oe_o(joe), .port_j_pullup_o(jpu),
    .port_k_pad_i(kin), .port_k_pad_o(ko), .port_k_pad_oe_o(koe), .port_k_pullup_o(kpu));
  gpjk_board i_board (.mclk_i(mclk_i), .ext_en_i(ext_en), .ext_j_i(ext_j), .ext_k_i(ext_k),
    .j_o_i(jo), .j_oe_i(joe), .j_pu_i(jpu), .k_o_i(ko), .k_oe_i(koe), .k_pu_i(kpu),
    .j_pad_o(jin), .k_pad_o(kin));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  // ==============================
  // tasks
  task summarize;
    begin
      if (fail_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  // request held until ack is seen at an edge, then released for one idle cycle
  task wb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge mclk_i);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge mclk_i);
        n = n + 1;
      end
      if (n >= 20) fail_count = fail_count + 1;
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk_i);
    end
  endtask
  initial begin
    #40000;
    fail_count = fail_count + 1;
    summarize;
  end
  // ==============================
  // tests
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    for (i = 0; i < 10; i = i + 1) begin
      wb(1'b0, OFFS[8*i +: 8], 32'h0);
      chk(got, 32'h0);
    end
    for (i = 0; i < 10; i = i + 1) begin
      wb(1'b1, OFFS[8*i +: 8], 32'hFFFFFFFF);
      wb(1'b0, OFFS[8*i +: 8], 32'h0);
      chk(got, {24'h0, MSKS[8*i +: 8]});
    end
    chk(32'(jpu), 32'hFF);
    chk(32'(kpu), 32'h6);
    chk(32'(koe), 32'h6);
    chk(32'(ko[2:1]), 32'h3);
    cec <= 1'b1;
    alm <= 1'b0;
    @(posedge mclk_i);
    chk(32'(koe), 32'h7);
    chk({31'h0, cec_line}, 32'h0);
    chk(32'(ko[1]), 32'h0);
    wb(1'b1, 8'h0C, 32'h0);
    chk(32'(ko[1]), 32'h1);
    wb(1'b1, 8'h44, 32'h30);
    chk(32'(joe), 32'h30);
    chk(32'(jo[5:4]), 32'h1);
    ext_en <= 1'b1;
    @(posedge mclk_i);
    chk(32'(irq), 32'h85);
    wb(1'b1, 8'h48, 32'h0);
    chk(32'(irq), 32'h85);
    wb(1'b1, 8'h40, 32'h20);
    chk(32'(jo & joe), 32'h20);
    wb(1'b0, 8'h7C, 32'h0);
    chk(got, 32'hA5);
    deep <= 1'b1;
    @(posedge mclk_i);
    chk(32'(irq), 32'h0);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b1, 8'h04, 32'h5);
    chk(32'(koe), 32'h5);
    wb(1'b0, 8'h3C, 32'h0);
    chk(got, 32'h2);
    // second reset with drivers and pull-ups on, functions all cleared
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    chk(32'(koe), 32'h0);
    chk(32'(kpu), 32'h0);
    chk(32'(joe), 32'h0);
    chk(32'(jpu), 32'h0);
    wb(1'b0, 8'h48, 32'h0);
    chk(got, 32'h0);
    summarize;
  end
endmodule // gpio_ports_j_k_function_mux_bench
